// File: rtl/crc_cfg.svh
// Purpose: Addresses, field positions and reset values of the clock/reset
//          control block.
// Assumes: Register address is {page, register} on a 16-bit port.
// Notes:   Mode register answers on every page, like a system register.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

`define CRC_PG_WAIT        8'h00
`define CRC_PG_RESET       8'h37
`define CRC_PG_TIMING      8'h27

`define CRC_R_MODE_CLK     8'heb
`define CRC_R_WAIT         8'hfc
`define CRC_R_HALT_CFG     8'hfb
`define CRC_R_CAUSE        8'hfe
`define CRC_R_CORE_MULT    8'hfd
`define CRC_R_DOT_MULT     8'hfe
`define CRC_R_PIXEL        8'hfb

`define CRC_RST_MODE       8'he0
`define CRC_RST_WAIT       8'h7f
`define CRC_RST_HALT_CFG   8'h07
`define CRC_RST_MULT       8'h00
`define CRC_RST_PIXEL      8'h00

`define CRC_M_MODE         8'h3c
`define CRC_M_WAIT         8'h7f
`define CRC_M_HALT_CFG     8'h80
`define CRC_M_MULT         8'hcf
`define CRC_M_PIXEL        8'h80

`define CRC_CAUSE_SOFT     8'h20
`define CRC_CAUSE_WDG      8'h40
`define CRC_CAUSE_EXT      8'h00

`define CRC_F_OSC_HALVING  5
`define CRC_F_PRS_HI       4
`define CRC_F_PRS_LO       2
`define CRC_F_TIMER_MODE   6
`define CRC_F_DWAIT_HI     5
`define CRC_F_DWAIT_LO     3
`define CRC_F_PWAIT_HI     2
`define CRC_F_PWAIT_LO     0
`define CRC_F_HALT_RST_EN  7
`define CRC_F_MULT_EN      7
`define CRC_F_CORE_SEL     6
`define CRC_F_DOT_HALVING  6
`define CRC_F_FACT_HI      3
`define CRC_F_FACT_LO      0
`define CRC_F_PIXEL_EN     7

`define CRC_SLC_PRE_4M     8'h40
`define CRC_SLC_PRE_8M     8'h80
`define CRC_SLC_MULT       10'h309

`endif

// File: rtl/crc_clk_switch.sv
// Purpose: Glitch-free core clock selection between crystal and multiplier.
// Assumes: Source levels are sampled on the system clock.
// Notes:   Each source is joined only while low; each is left only while low, except a disabled multiplier, left at any level.
`timescale 1ns/1ps
module crc_clk_switch
  import crc_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  crc_sw_if.sw      sw
);
  crc_sw_st_e st_r;
  crc_sw_st_e st_nxt;
  logic       clk_r;
  logic       clk_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SW_XTAL: begin
        if (sw.want_mult && !sw.xtal_lvl) st_nxt = SW_TO_MULT;
      end
      SW_TO_MULT: begin
        if (!sw.want_mult) st_nxt = SW_TO_XTAL;
        else if (!sw.mult_lvl) st_nxt = SW_MULT;
      end
      SW_MULT: begin
        // Dead multiplier may hold high; leaving then is the only way out
        if (!sw.want_mult && (!sw.mult_lvl || !sw.en)) begin
          st_nxt = SW_TO_XTAL;
        end
      end
      SW_TO_XTAL: begin
        if (!sw.xtal_lvl) st_nxt = SW_XTAL;
      end
    endcase
  end

  assign clk_nxt = ((st_r == SW_XTAL) && sw.xtal_lvl) ||
                   ((st_r == SW_MULT) && sw.mult_lvl);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r  <= SW_XTAL;
      clk_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign sw.clk_out = clk_r;
  assign sw.on_mult = (st_r == SW_MULT);

  a_switch_gap: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (st_r == SW_TO_MULT || st_r == SW_TO_XTAL) |=> !clk_r)
    else $error("core clock high during source changeover");
endmodule

// File: rtl/crc_pkg.sv
// Purpose: Types shared by the clock/reset control modules.
// Assumes: Constants come from crc_cfg.svh.
// Notes:   None.
package crc_pkg;
  typedef logic [7:0] crc_byte_t;
  typedef enum logic [1:0] {
    SW_XTAL,
    SW_TO_MULT,
    SW_MULT,
    SW_TO_XTAL
  } crc_sw_st_e;
endpackage

// File: rtl/crc_sw_if.sv
// Purpose: Carrier between the control logic and the core clock switch.
// Assumes: All members are levels sampled on the system clock.
// Notes:   None.
`timescale 1ns/1ps
interface crc_sw_if;
  logic want_mult;
  logic en;
  logic xtal_lvl;
  logic mult_lvl;
  logic clk_out;
  logic on_mult;
  modport ctl (output want_mult, en, xtal_lvl, mult_lvl,
               input  clk_out, on_mult);
  modport sw  (input  want_mult, en, xtal_lvl, mult_lvl,
               output clk_out, on_mult);
endinterface

// File: rtl/crc_top.sv
// Purpose: Clock dividers, wait states, reset cause and multiplier control.
// Assumes: All inputs synchronous to i_sys_clk; clock sources as levels.
// Notes:   Soft and watchdog resets reinitialise registers synchronously.
`timescale 1ns/1ps
`include "crc_cfg.svh"
module crc_top
  import crc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_halt,
  input  wire logic       i_wdg_timeout,
  input  wire logic       i_xtal_8mhz,
  input  wire logic       i_ext_start,
  input  wire logic       i_ext_is_data,
  output logic            o_ext_wait,
  output logic            o_int_tick,
  output logic            o_cpu_tick,
  output logic            o_watchdog_mode,
  output logic            o_sys_reset,
  output logic            o_pll_off,
  output logic            o_slowdown_off,
  output logic            o_core_mult_en,
  output logic      [3:0] o_core_mult_factor,
  input  wire logic       i_xtal_lvl,
  input  wire logic       i_fimf_lvl,
  output logic            o_core_clk,
  output logic            o_core_on_mult,
  output logic            o_dot_mult_en,
  output logic      [3:0] o_dot_mult_factor,
  input  wire logic       i_skew_lvl,
  output logic            o_dot_clk,
  output logic      [7:0] o_slicer_prescale,
  output logic      [9:0] o_slicer_mult,
  input  wire logic       i_pixel_lvl,
  output logic            o_pixel_clk,
  output logic            o_text_display_ram_clk
);
  crc_byte_t  mode_r;
  crc_byte_t  wait_r;
  crc_byte_t  hcfg_r;
  crc_byte_t  cause_r;
  crc_byte_t  core_r;
  crc_byte_t  dot_r;
  crc_byte_t  pix_r;
  crc_byte_t  rdata_r;
  crc_byte_t  rd_mux;
  logic       half_r;
  logic [2:0] prs_cnt_r;
  logic [2:0] prs_cnt_nxt;
  logic [2:0] wait_cnt_r;
  logic [2:0] wait_cnt_nxt;
  logic       pd_r;
  logic       sys_rst_r;
  logic       skew_q_r;
  logic       dot_div_r;
  logic       dot_clk_r;
  logic       pix_clk_r;
  logic       strap_done_r;
  logic       xtal8_r;
  crc_sw_if   sw_if ();

  function automatic crc_byte_t wr_mask(input crc_byte_t d,
                                        input crc_byte_t m,
                                        input crc_byte_t rst);
    wr_mask = (d & m) | (rst & ~m);
  endfunction

  // Address decode
  wire [7:0] pg        = i_addr[15:8];
  wire [7:0] rg        = i_addr[7:0];
  wire       sel_mode  = (rg == `CRC_R_MODE_CLK);
  wire       sel_wait  = (pg == `CRC_PG_WAIT) && (rg == `CRC_R_WAIT);
  wire       sel_hcfg  = (pg == `CRC_PG_RESET) && (rg == `CRC_R_HALT_CFG);
  wire       sel_cause = (pg == `CRC_PG_RESET) && (rg == `CRC_R_CAUSE);
  wire       sel_core  = (pg == `CRC_PG_TIMING) && (rg == `CRC_R_CORE_MULT);
  wire       sel_dot   = (pg == `CRC_PG_TIMING) && (rg == `CRC_R_DOT_MULT);
  wire       sel_pix   = (pg == `CRC_PG_TIMING) && (rg == `CRC_R_PIXEL);

  // Fields
  wire       osc_halving  = mode_r[`CRC_F_OSC_HALVING];
  wire [2:0] cpu_prescale = mode_r[`CRC_F_PRS_HI:`CRC_F_PRS_LO];
  wire       timer_mode   = wait_r[`CRC_F_TIMER_MODE];
  wire [2:0] data_wait    = wait_r[`CRC_F_DWAIT_HI:`CRC_F_DWAIT_LO];
  wire [2:0] prog_wait    = wait_r[`CRC_F_PWAIT_HI:`CRC_F_PWAIT_LO];
  wire       halt_rst_en  = hcfg_r[`CRC_F_HALT_RST_EN];
  wire       core_en      = core_r[`CRC_F_MULT_EN];
  wire       core_sel     = core_r[`CRC_F_CORE_SEL];
  wire       dot_en       = dot_r[`CRC_F_MULT_EN];
  wire       dot_halving  = dot_r[`CRC_F_DOT_HALVING];
  wire       pix_en       = pix_r[`CRC_F_PIXEL_EN];

  // Reset events and HALT handling
  wire soft_rst  = i_halt && halt_rst_en;
  wire sync_init = soft_rst || i_wdg_timeout;
  wire halt_pd   = i_halt && !halt_rst_en && !i_wdg_timeout;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_r <= `CRC_RST_MODE;
      wait_r <= `CRC_RST_WAIT;
      hcfg_r <= `CRC_RST_HALT_CFG;
      pix_r  <= `CRC_RST_PIXEL;
    end else if (sync_init) begin
      mode_r <= `CRC_RST_MODE;
      wait_r <= `CRC_RST_WAIT;
      hcfg_r <= `CRC_RST_HALT_CFG;
      pix_r  <= `CRC_RST_PIXEL;
    end else if (i_wr) begin
      if (sel_mode) mode_r <= wr_mask(i_wdata, `CRC_M_MODE, `CRC_RST_MODE);
      if (sel_wait) wait_r <= wr_mask(i_wdata, `CRC_M_WAIT, `CRC_RST_WAIT);
      if (sel_hcfg) begin
        hcfg_r <= wr_mask(i_wdata, `CRC_M_HALT_CFG, `CRC_RST_HALT_CFG);
      end
      if (sel_pix) pix_r <= wr_mask(i_wdata, `CRC_M_PIXEL, `CRC_RST_PIXEL);
    end
  end

  // Multiplier controls: off at reset and forced back on any HALT
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_r <= `CRC_RST_MULT;
      dot_r  <= `CRC_RST_MULT;
    end else if (i_halt || i_wdg_timeout) begin
      core_r <= `CRC_RST_MULT;
      dot_r  <= `CRC_RST_MULT;
    end else if (i_wr) begin
      if (sel_core) core_r <= wr_mask(i_wdata, `CRC_M_MULT, `CRC_RST_MULT);
      if (sel_dot)  dot_r  <= wr_mask(i_wdata, `CRC_M_MULT, `CRC_RST_MULT);
    end
  end

  // Cause of last reset; only reset events change it
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cause_r <= `CRC_CAUSE_EXT;
    end else if (i_wdg_timeout) begin
      cause_r <= `CRC_CAUSE_WDG;
    end else if (soft_rst) begin
      cause_r <= `CRC_CAUSE_SOFT;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pd_r      <= 1'b0;
      sys_rst_r <= 1'b0;
    end else begin
      sys_rst_r <= sync_init;
      if (sync_init) pd_r <= 1'b0;
      else if (halt_pd) pd_r <= 1'b1;
    end
  end

  // Read port: data one cycle after the strobe, zero otherwise
  assign rd_mux = sel_mode  ? mode_r :
                  sel_wait  ? wait_r :
                  sel_hcfg  ? hcfg_r :
                  sel_cause ? cause_r :
                  sel_core  ? core_r :
                  sel_dot   ? dot_r :
                  sel_pix   ? pix_r : 8'h00;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) rdata_r <= 8'h00;
    else rdata_r <= i_rd ? rd_mux : 8'h00;
  end

  // Internal clock and CPU prescaler
  wire int_tick = !osc_halving || half_r;
  wire prs_hit  = (prs_cnt_r >= cpu_prescale);
  wire cpu_tick = int_tick && prs_hit;
  assign prs_cnt_nxt = !int_tick ? prs_cnt_r :
                       prs_hit   ? 3'h0 : 3'(prs_cnt_r + 3'h1);

  // External memory wait states, counted on the internal clock
  assign wait_cnt_nxt =
    i_ext_start ? (i_ext_is_data ? data_wait : prog_wait) :
    ((wait_cnt_r != 3'h0) && int_tick) ? 3'(wait_cnt_r - 3'h1) :
    wait_cnt_r;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      half_r     <= 1'b0;
      prs_cnt_r  <= 3'h0;
      wait_cnt_r <= 3'h0;
    end else begin
      half_r     <= !half_r;
      prs_cnt_r  <= prs_cnt_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // Dot clock path and pixel gate
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      skew_q_r  <= 1'b0;
      dot_div_r <= 1'b0;
      dot_clk_r <= 1'b0;
      pix_clk_r <= 1'b0;
    end else begin
      skew_q_r <= i_skew_lvl;
      if (!dot_en) dot_div_r <= 1'b0;
      else if (i_skew_lvl && !skew_q_r) dot_div_r <= !dot_div_r;
      dot_clk_r <= dot_en && (dot_halving ? skew_q_r : dot_div_r);
      pix_clk_r <= pix_en && i_pixel_lvl;
    end
  end

  // Crystal strap taken once after reset release
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_done_r <= 1'b0;
      xtal8_r      <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      xtal8_r      <= i_xtal_8mhz;
    end
  end

  // Core clock selection
  assign sw_if.want_mult = core_sel && core_en;
  assign sw_if.en        = core_en;
  assign sw_if.xtal_lvl  = i_xtal_lvl;
  assign sw_if.mult_lvl  = i_fimf_lvl;

  crc_clk_switch u_switch (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .sw        (sw_if)
  );

  assign o_rdata            = rdata_r;
  assign o_ext_wait         = (wait_cnt_r != 3'h0);
  assign o_int_tick         = int_tick;
  assign o_cpu_tick         = cpu_tick;
  assign o_watchdog_mode    = !timer_mode;
  assign o_sys_reset        = sys_rst_r;
  assign o_pll_off          = pd_r;
  assign o_slowdown_off     = pd_r;
  assign o_core_mult_en     = core_en;
  assign o_core_mult_factor = core_r[`CRC_F_FACT_HI:`CRC_F_FACT_LO];
  assign o_core_clk         = sw_if.clk_out;
  assign o_core_on_mult     = sw_if.on_mult;
  assign o_dot_mult_en      = dot_en;
  assign o_dot_mult_factor  = dot_r[`CRC_F_FACT_HI:`CRC_F_FACT_LO];
  assign o_dot_clk          = dot_clk_r;
  assign o_slicer_prescale  = xtal8_r ? `CRC_SLC_PRE_8M : `CRC_SLC_PRE_4M;
  assign o_slicer_mult      = `CRC_SLC_MULT;
  assign o_pixel_clk        = pix_clk_r;
  assign o_text_display_ram_clk       = pix_clk_r;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_int_tick_half: assert property (
    osc_halving && int_tick && !i_wr |=> !int_tick)
    else $error("halved internal clock ticked twice in a row");

  a_cpu_no_prs: assert property (
    (cpu_prescale == 3'h0) && int_tick |-> cpu_tick)
    else $error("cpu tick missing with prescale zero");

  a_wait_data_load: assert property (
    i_ext_start && i_ext_is_data && !sync_init
      |=> wait_cnt_r == $past(data_wait))
    else $error("data wait count not loaded");

  a_wait_prog_load: assert property (
    i_ext_start && !i_ext_is_data && !sync_init
      |=> wait_cnt_r == $past(prog_wait))
    else $error("program wait count not loaded");

  a_wait_int_only: assert property (
    o_ext_wait && !int_tick && !i_ext_start |=> $stable(wait_cnt_r))
    else $error("wait counted without internal tick");

  a_wdg_mode_wr: assert property (
    i_wr && sel_wait && !i_wdata[`CRC_F_TIMER_MODE] && !sync_init
      |=> o_watchdog_mode)
    else $error("watchdog mode not entered");

  a_halt_soft_rst: assert property (
    soft_rst && !i_wdg_timeout
      |=> o_sys_reset && cause_r == `CRC_CAUSE_SOFT && !o_pll_off)
    else $error("halt reset not taken");

  a_halt_pwr_down: assert property (
    halt_pd |=> o_pll_off && o_slowdown_off && !o_sys_reset)
    else $error("halt did not power down");

  a_wdg_cause: assert property (
    i_wdg_timeout |=> cause_r == `CRC_CAUSE_WDG ##1
      (cause_r == `CRC_CAUSE_WDG || $past(sync_init)))
    else $error("watchdog cause lost");

  a_halt_mult_off: assert property (
    i_halt |=> !o_core_mult_en && !o_dot_mult_en && core_r == `CRC_RST_MULT)
    else $error("halt left a multiplier running");

  a_core_fallback: assert property (
    !core_en |-> ##[0:3] !sw_if.want_mult && (!o_core_on_mult ||
      $past(core_en)))
    else $error("core clock not forced to crystal");

  a_pixel_gate: assert property (
    !pix_en |=> !o_pixel_clk && !o_text_display_ram_clk)
    else $error("pixel clock leaked while gated");

  a_cause_hold: assert property (
    !sync_init |=> cause_r == $past(cause_r))
    else $error("reset cause changed without a reset event");

  a_slicer_fixed: assert property (
    o_slicer_mult == `CRC_SLC_MULT &&
      (o_slicer_prescale == `CRC_SLC_PRE_4M ||
       o_slicer_prescale == `CRC_SLC_PRE_8M))
    else $error("slicer prescale or multiply outside allowed pair");

  a_dot_bypass: assert property (
    dot_en && dot_halving |=> o_dot_clk == $past(skew_q_r))
    else $error("undivided dot clock does not follow skew output");

  a_dot_off: assert property (
    !dot_en |=> !o_dot_clk)
    else $error("dot clock running with multiplier off");

  a_mult_init: assert property (
    sync_init |=> core_r == `CRC_RST_MULT && dot_r == `CRC_RST_MULT)
    else $error("multiplier left on across a reset");

  a_cpu_prs_div: assert property (
    cpu_tick && (cpu_prescale != 3'h0) && !i_wr && !sync_init
      |=> !cpu_tick)
    else $error("prescaled cpu clock ticked twice in a row");

  c_soft_reset:  cover property (soft_rst);
  c_wdg_reset:   cover property (i_wdg_timeout);
  c_on_mult:     cover property ($rose(o_core_on_mult));
  c_full_wait:   cover property (o_ext_wait [*7] ##1 !o_ext_wait);
  c_pwr_down:    cover property (halt_pd);
endmodule

// File: verif/crc_tb.sv
// Purpose: Self-checking bench for the clock/reset control block.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes:   Clock source levels are synthetic toggle patterns.
`timescale 1ns/1ps
`include "crc_cfg.svh"
module testbench
  import crc_pkg::*;
;
  logic        i_sys_clk = 1'b0, i_arst_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_halt = 1'b0;
  logic        i_wdg_timeout = 1'b0, i_xtal_8mhz = 1'b0;
  logic        i_ext_start = 1'b0, i_ext_is_data = 1'b0;
  logic        i_xtal_lvl = 1'b0, i_fimf_lvl = 1'b0;
  logic        i_skew_lvl = 1'b0, i_pixel_lvl = 1'b0;
  logic [7:0]  o_rdata, o_slicer_prescale;
  logic [3:0]  o_core_mult_factor, o_dot_mult_factor;
  logic [9:0]  o_slicer_mult;
  logic        o_ext_wait, o_int_tick, o_cpu_tick, o_watchdog_mode;
  logic        o_sys_reset, o_pll_off, o_slowdown_off, o_core_mult_en;
  logic        o_core_clk, o_core_on_mult, o_dot_mult_en, o_dot_clk;
  logic        o_pixel_clk, o_text_display_ram_clk;
  int          n_fail = 0, samples_checked = 0;
  int unsigned cyc_n = 0;
  logic [31:0] seed = 32'h3cc4258b;

  localparam logic [15:0] A_MODE  = {8'h12, `CRC_R_MODE_CLK};
  localparam logic [15:0] A_WAIT  = {`CRC_PG_WAIT, `CRC_R_WAIT};
  localparam logic [15:0] A_HALT  = {`CRC_PG_RESET, `CRC_R_HALT_CFG};
  localparam logic [15:0] A_CAUSE = {`CRC_PG_RESET, `CRC_R_CAUSE};
  localparam logic [15:0] A_CORE  = {`CRC_PG_TIMING, `CRC_R_CORE_MULT};
  localparam logic [15:0] A_DOT   = {`CRC_PG_TIMING, `CRC_R_DOT_MULT};
  localparam logic [15:0] A_PIX   = {`CRC_PG_TIMING, `CRC_R_PIXEL};
  logic [15:0] amap [6] = '{A_MODE, A_WAIT, A_HALT, A_CORE, A_DOT, A_PIX};
  logic [7:0]  rstv [6] = '{8'he0, 8'h7f, 8'h07, 8'h00, 8'h00, 8'h00};

  crc_top dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_halt(i_halt), .i_wdg_timeout(i_wdg_timeout),
    .i_xtal_8mhz(i_xtal_8mhz), .i_ext_start(i_ext_start),
    .i_ext_is_data(i_ext_is_data), .o_ext_wait(o_ext_wait),
    .o_int_tick(o_int_tick), .o_cpu_tick(o_cpu_tick),
    .o_watchdog_mode(o_watchdog_mode), .o_sys_reset(o_sys_reset),
    .o_pll_off(o_pll_off), .o_slowdown_off(o_slowdown_off),
    .o_core_mult_en(o_core_mult_en),
    .o_core_mult_factor(o_core_mult_factor), .i_xtal_lvl(i_xtal_lvl),
    .i_fimf_lvl(i_fimf_lvl), .o_core_clk(o_core_clk),
    .o_core_on_mult(o_core_on_mult), .o_dot_mult_en(o_dot_mult_en),
    .o_dot_mult_factor(o_dot_mult_factor), .i_skew_lvl(i_skew_lvl),
    .o_dot_clk(o_dot_clk), .o_slicer_prescale(o_slicer_prescale),
    .o_slicer_mult(o_slicer_mult), .i_pixel_lvl(i_pixel_lvl),
    .o_pixel_clk(o_pixel_clk), .o_text_display_ram_clk(o_text_display_ram_clk)
  );

  always #2 i_sys_clk = ~i_sys_clk;

  // Source levels: crystal and skew at half rate, multiplier at a sixth
  always @(posedge i_sys_clk) begin
    cyc_n <= cyc_n + 1;
    i_xtal_lvl <= ~i_xtal_lvl;
    i_skew_lvl <= ~i_skew_lvl;
    i_pixel_lvl <= cyc_n[1];
    if (cyc_n % 3 == 0) i_fimf_lvl <= ~i_fimf_lvl;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] exp_rd(int k, logic [7:0] d);
    case (k)
      0: return (d & 8'h3c) | 8'hc0;
      1: return d & 8'h7f;
      2: return (d & 8'h80) | 8'h07;
      3, 4: return d & 8'hcf;
      default: return d & 8'h80;
    endcase
  endfunction

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc();
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic do_reset(logic s);
    i_arst_n <= 1'b0;
    i_xtal_8mhz <= s;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    cyc();
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(string nm, logic [15:0] a, logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    check(nm, o_rdata, e);
  endtask

  task automatic pulse(logic wdg);
    @(posedge i_sys_clk);
    if (wdg) i_wdg_timeout <= 1'b1;
    else i_halt <= 1'b1;
    @(posedge i_sys_clk);
    i_wdg_timeout <= 1'b0;
    i_halt <= 1'b0;
    #1;
  endtask

  task automatic ext(logic dat, int e);
    int c = 0;
    @(posedge i_sys_clk);
    i_ext_start <= 1'b1;
    i_ext_is_data <= dat;
    @(posedge i_sys_clk);
    i_ext_start <= 1'b0;
    #1;
    while (o_ext_wait === 1'b1 && c < 40) begin
      c++;
      cyc();
    end
    check("ext_wait", 16'(c), 16'(e));
  endtask

  // Output w follows source w one cycle late while on is set
  // Undivided dot path has one stage more: compare with the older sample
  task automatic lag(int w, logic on);
    logic [3:0] s;
    logic [3:0] p;
    logic [3:0] o;
    logic       e;
    s = {i_pixel_lvl, i_skew_lvl, i_fimf_lvl, i_xtal_lvl};
    cyc();
    repeat (8) begin
      p = s;
      s = {i_pixel_lvl, i_skew_lvl, i_fimf_lvl, i_xtal_lvl};
      cyc();
      o = {o_pixel_clk, o_dot_clk, o_core_clk, o_core_clk};
      e = ((w == 2) ? p[w] : s[w]) & on;
      check("clk_lag", o[w], e);
      if (w == 3) check("text_display_ram", o_text_display_ram_clk, e);
    end
  endtask

  task automatic core_wait(logic e);
    int c = 0;
    while (o_core_on_mult !== e && c < 20) begin
      c++;
      cyc();
    end
    check("on_mult", o_core_on_mult, e);
  endtask

  initial begin
    int cnt;
    logic [7:0] v;
    logic pv;
    do_reset(1'b0);
    check("slc_pre", o_slicer_prescale, 8'h40);
    check("slc_mult", o_slicer_mult, 16'd777);
    check("wdg_mode", o_watchdog_mode, 1'b0);
    check("mults", {o_core_mult_en, o_dot_mult_en}, 2'b00);
    for (int k = 0; k < 6; k++) rchk("rst_val", amap[k], rstv[k]);
    rchk("cause_ext", A_CAUSE, 8'h00);
    wr(A_CAUSE, 8'hff);
    rchk("cause_ro", A_CAUSE, 8'h00);
    wr(16'h00fd, 8'hff);
    rchk("unmapped", 16'h00fd, 8'h00);
    repeat (10) begin
      for (int k = 0; k < 6; k++) begin
        v = rnd();
        wr(amap[k], v);
        rchk("reg_rw", amap[k], exp_rd(k, v));
        if (k == 1) check("wdg_mode", o_watchdog_mode, !v[6]);
        if (k == 3) check("core_f", {o_core_mult_en, o_core_mult_factor}, {v[7], v[3:0]});
        if (k == 4) check("dot_f", {o_dot_mult_en, o_dot_mult_factor}, {v[7], v[3:0]});
      end
    end
    do_reset(1'b0);
    for (int h = 0; h < 2; h++) begin
      for (int p = 0; p < 8; p++) begin
        wr(A_MODE, {2'b00, h[0], p[2:0], 2'b00});
        cnt = 0;
        v = 8'h00;
        repeat (1680) begin
          cyc();
          cnt += (o_cpu_tick === 1'b1);
          v += 8'((o_int_tick === 1'b1) && h == 1);
        end
        check("cpu_ticks", 16'(cnt), 16'(1680 / ((p + 1) * (h + 1))));
        if (h == 1) check("int_ticks", 16'(v), 16'(840 % 256));
      end
    end
    wr(A_MODE, 8'h1c);
    for (int n = 0; n < 8; n++) begin
      wr(A_WAIT, {2'b01, n[2:0], 3'(7 - n)});
      ext(1'b1, n);
      ext(1'b0, 7 - n);
    end
    wr(A_CORE, 8'h05);
    wr(A_CORE, 8'h85);
    core_wait(1'b0);
    lag(0, 1'b1);
    wr(A_CORE, 8'hc5);
    core_wait(1'b1);
    lag(1, 1'b1);
    wr(A_CORE, 8'h45);
    core_wait(1'b0);
    repeat (3) cyc();
    lag(0, 1'b1);
    wr(A_DOT, 8'h48);
    lag(2, 1'b0);
    wr(A_DOT, 8'hc8);
    lag(2, 1'b1);
    wr(A_DOT, 8'h88);
    cnt = 0;
    pv = o_dot_clk;
    repeat (64) begin
      cyc();
      cnt += (o_dot_clk === 1'b1 && pv === 1'b0);
      pv = o_dot_clk;
    end
    check("dot_half", cnt >= 15 && cnt <= 17, 1'b1);
    wr(A_PIX, 8'h00);
    lag(3, 1'b0);
    wr(A_PIX, 8'h80);
    lag(3, 1'b1);
    wr(A_CORE, 8'h85);
    wr(A_HALT, 8'h07);
    pulse(1'b0);
    check("halt_off", {o_pll_off, o_slowdown_off, o_sys_reset}, 3'b110);
    check("halt_mult", {o_core_mult_en, o_dot_mult_en}, 2'b00);
    rchk("halt_core", A_CORE, 8'h00);
    rchk("halt_dot", A_DOT, 8'h00);
    pulse(1'b1);
    check("wdg_rst", {o_sys_reset, o_pll_off}, 2'b10);
    rchk("cause_wdg", A_CAUSE, 8'h40);
    rchk("wait_rst", A_WAIT, 8'h7f);
    rchk("pix_rst", A_PIX, 8'h00);
    wr(A_HALT, 8'h87);
    pulse(1'b0);
    check("soft_rst", {o_sys_reset, o_pll_off}, 2'b10);
    rchk("cause_soft", A_CAUSE, 8'h20);
    do_reset(1'b1);
    check("slc_pre8", o_slicer_prescale, 8'h80);
    rchk("cause_ext2", A_CAUSE, 8'h00);
    finish_test();
  end

  initial begin
    #300000;
    n_fail++;
    finish_test();
  end
endmodule
